// [rtl/stho_pkg.sv]
// Constants, register map and code expansion for the threshold, history and offset block.
// Assumes one 50 MHz clock domain; register indices sit at byte address index*4.
package stho_pkg;

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_PROX_HYST = 8'h17;
    localparam logic [7:0] IDX_PROX_HIST = 8'h18;
    localparam logic [7:0] IDX_AMB_HIST = 8'h19;
    localparam logic [7:0] IDX_MEAS_OFS = 8'h1a;
    localparam logic [7:0] IDX_EMIT_REC = 8'h1c;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
    localparam logic [7:0] IDX_RESULT_LO = 8'h22;
    localparam logic [7:0] IDX_RESULT_HI = 8'h23;
    localparam logic [7:0] IDX_CHAN_STAT = 8'h24;

    // Values after reset
    localparam logic [7:0] RST_PROX_HYST = 8'h48;
    localparam logic [7:0] RST_PROX_HIST = 8'h03;
    localparam logic [7:0] RST_AMB_HIST = 8'h03;
    localparam logic [7:0] RST_MEAS_OFS = 8'h80;
    localparam logic [7:0] RST_EMIT_REC = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // Status bit positions: one change event per channel, then overrange
    localparam int NCHAN = 4;
    localparam int AMB_CHAN = 3;
    localparam int EVT_OVR = 4;
    localparam int NEVT = 5;

    // Reserved result codes
    localparam logic [15:0] RES_OVERRANGE = 16'hffff;
    localparam logic [15:0] RES_CLAMP = 16'hfffe;

    // Channel decision state, one-hot
    typedef enum logic [1:0] {
        ST_BELOW = 2'b01,
        ST_ABOVE = 2'b10
    } stho_state_t;

    // Compressed code: high nibble exponent, low nibble fraction, value 1.f * 2^e
    function automatic logic [15:0] stho_expand(input logic [7:0] code);
        logic [19:0] mant;
        mant = {15'h0000, 1'b1, code[3:0]} << code[7:4];
        return mant[19:4];
    endfunction

endpackage

// [rtl/stho_chan_if.sv]
// Per-channel link between the register/measurement logic and a history filter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface stho_chan_if;
    logic smp_vld;
    logic [15:0] value;
    logic [15:0] threshold;
    logic [15:0] hyst;
    logic [7:0] mask;
    logic above;
    logic changed;

    modport filt (
        input smp_vld,
        input value,
        input threshold,
        input hyst,
        input mask,
        output above,
        output changed
    );

    modport ctl (
        output smp_vld,
        output value,
        output threshold,
        output hyst,
        output mask,
        input above,
        input changed
    );
endinterface

// [rtl/stho_hist_filter.sv]
// History filter for one channel: status flips after a run of samples beyond the band.
// Assumes samples arrive as single-cycle strobes on the shared clock.
`timescale 1ns/1ps
module stho_hist_filter
    import stho_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Channel link
    stho_chan_if.filt ch
);

    stho_state_t state_ff;
    stho_state_t nxt_state;
    logic [7:0] hist_ff;
    logic [7:0] nxt_hist;
    logic changed_ff;
    logic [16:0] band_hi;
    logic [15:0] band_lo;
    logic beyond;
    logic run_met;

    // Band edges, upper widened to 17 bits and lower saturating at zero, so a wide band never wraps
    assign band_hi = {1'b0, ch.threshold} + {1'b0, ch.hyst};
    assign band_lo = (ch.threshold >= ch.hyst) ? ch.threshold - ch.hyst : 16'h0000;
    // Beyond means past the far edge of the band for the current state
    assign beyond = (state_ff == ST_BELOW) ? ({1'b0, ch.value} > band_hi)
                                           : (ch.value < band_lo);
    assign nxt_hist = {hist_ff[6:0], beyond};
    assign run_met = beyond && ((nxt_hist & ch.mask) == ch.mask);
    assign nxt_state = (state_ff == ST_BELOW) ? ST_ABOVE : ST_BELOW;

    // History restarts after each flip so the next run is counted afresh
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= ST_BELOW;
            hist_ff <= 8'h00;
            changed_ff <= 1'b0;
        end
        else
        begin
            changed_ff <= ch.smp_vld && run_met;
            if (ch.smp_vld)
            begin
                hist_ff <= run_met ? 8'h00 : nxt_hist;
                if (run_met)
                begin
                    state_ff <= nxt_state;
                end
            end
        end
    end

    assign ch.above = (state_ff == ST_ABOVE);
    assign ch.changed = changed_ff;

    // A lone sample never satisfies a two-sample mask
    short_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ch.smp_vld && beyond && !hist_ff[0] && ch.mask[1] |=> !changed_ff)
        else $error("status changed on a run shorter than the mask");

    // A completed run flips the status on the next edge
    full_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ch.smp_vld && run_met |=> changed_ff && (state_ff != $past(state_ff)))
        else $error("completed run did not flip the status");

endmodule

// [rtl/stho_top.sv]
// Threshold hysteresis, history filtering and offset for a light sensor's result path.
// Assumes a classic Wishbone master and measurement strobes on the same 50 MHz clock.
`timescale 1ns/1ps
module stho_top
    import stho_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Raw measurement from the converter path
    input wire logic meas_vld_i,
    input wire logic [1:0] meas_chan_i,
    input wire logic [15:0] meas_i,
    input wire logic meas_ovr_i,
    // Thresholds from the threshold registers
    input wire logic [15:0] proximity_channel1_threshold_i,
    input wire logic [15:0] proximity_channel2_threshold_i,
    input wire logic [15:0] proximity_channel3_threshold_i,
    input wire logic [15:0] ambient_threshold_i,
    // Reported result
    output logic [15:0] result_o,
    output logic result_vld_o,
    output logic [1:0] result_chan_o,
    // Decisions and interrupt
    output logic [2:0] proximity_near_o,
    output logic ambient_above_o,
    output logic irq_o
);

    // Registers
    logic [7:0] proximity_hysteresis_ff;
    logic [7:0] proximity_history_mask_ff;
    logic [7:0] ambient_history_mask_ff;
    logic [7:0] measurement_offset_ff;
    logic [7:0] emitter_recovery_reserved_ff;
    logic [NEVT-1:0] irq_stat_ff;
    logic [NEVT-1:0] nxt_irq_stat;
    logic [NEVT-1:0] irq_mask_ff;
    logic ack_ff;
    logic [31:0] rd_data_ff;
    logic [15:0] result_ff;
    logic result_vld_ff;
    logic [1:0] result_chan_ff;
    logic ovr_ff;

    // Bus decode
    logic req;
    logic wr;
    logic [7:0] idx;
    logic sel_prox_hyst;
    logic sel_prox_hist;
    logic sel_amb_hist;
    logic sel_meas_ofs;
    logic sel_emit_rec;
    logic sel_irq_stat;
    logic sel_irq_mask;
    logic sel_res_lo;
    logic sel_res_hi;
    logic sel_chan_stat;
    logic [7:0] rd_byte;

    // Datapath
    logic [15:0] prox_hyst_val;
    logic [15:0] ofs_val;
    logic [15:0] sum;
    logic [15:0] reported;
    logic [NCHAN-1:0] chan_above;
    logic [NCHAN-1:0] chan_changed;
    logic [15:0] thr_w [NCHAN];
    logic [NEVT-1:0] evt_set;
    logic [NEVT-1:0] evt_clr;

    // One request per access; ack high blocks a second take of the same cycle
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];

    // Address decode
    assign sel_prox_hyst = (idx == IDX_PROX_HYST);
    assign sel_prox_hist = (idx == IDX_PROX_HIST);
    assign sel_amb_hist = (idx == IDX_AMB_HIST);
    assign sel_meas_ofs = (idx == IDX_MEAS_OFS);
    assign sel_emit_rec = (idx == IDX_EMIT_REC);
    assign sel_irq_stat = (idx == IDX_IRQ_STAT);
    assign sel_irq_mask = (idx == IDX_IRQ_MASK);
    assign sel_res_lo = (idx == IDX_RESULT_LO);
    assign sel_res_hi = (idx == IDX_RESULT_HI);
    assign sel_chan_stat = (idx == IDX_CHAN_STAT);

    // Read selection; unmapped indices read as zero but still get an ack
    assign rd_byte = sel_prox_hyst ? proximity_hysteresis_ff :
                     sel_prox_hist ? proximity_history_mask_ff :
                     sel_amb_hist ? ambient_history_mask_ff :
                     sel_meas_ofs ? measurement_offset_ff :
                     sel_emit_rec ? emitter_recovery_reserved_ff :
                     sel_irq_stat ? {3'h0, irq_stat_ff} :
                     sel_irq_mask ? {3'h0, irq_mask_ff} :
                     sel_res_lo ? result_ff[7:0] :
                     sel_res_hi ? result_ff[15:8] :
                     sel_chan_stat ? {4'h0, chan_above} :
                     8'h00;

    // Bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_ff <= 1'b0;
            rd_data_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= req;
            if (req)
            begin
                rd_data_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rd_data_ff;

    // Parameter registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            proximity_hysteresis_ff <= RST_PROX_HYST;
            proximity_history_mask_ff <= RST_PROX_HIST;
            ambient_history_mask_ff <= RST_AMB_HIST;
            measurement_offset_ff <= RST_MEAS_OFS;
            emitter_recovery_reserved_ff <= RST_EMIT_REC;
            irq_mask_ff <= RST_IRQ_MASK[NEVT-1:0];
        end
        else if (wr)
        begin
            if (sel_prox_hyst)
            begin
                proximity_hysteresis_ff <= wb_dat_i[7:0];
            end
            if (sel_prox_hist)
            begin
                proximity_history_mask_ff <= wb_dat_i[7:0];
            end
            if (sel_amb_hist)
            begin
                ambient_history_mask_ff <= wb_dat_i[7:0];
            end
            if (sel_meas_ofs)
            begin
                measurement_offset_ff <= wb_dat_i[7:0];
            end
            // Stored only; nothing inside reads it
            if (sel_emit_rec)
            begin
                emitter_recovery_reserved_ff <= wb_dat_i[7:0];
            end
            if (sel_irq_mask)
            begin
                irq_mask_ff <= wb_dat_i[NEVT-1:0];
            end
        end
    end

    assign prox_hyst_val = stho_expand(proximity_hysteresis_ff);
    assign ofs_val = stho_expand(measurement_offset_ff);

    assign sum = meas_i + ofs_val;
    assign reported = meas_ovr_i ? RES_OVERRANGE :
                      (sum == RES_OVERRANGE) ? RES_CLAMP : sum;

    // Result register; offset sums past 16 bits wrap, and only a sum of 0xffff moves to the clamp code
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            result_ff <= 16'h0000;
            result_vld_ff <= 1'b0;
            result_chan_ff <= 2'h0;
            ovr_ff <= 1'b0;
        end
        else
        begin
            result_vld_ff <= meas_vld_i;
            if (meas_vld_i)
            begin
                result_ff <= reported;
                result_chan_ff <= meas_chan_i;
                ovr_ff <= meas_ovr_i;
            end
        end
    end

    assign result_o = result_ff;
    assign result_vld_o = result_vld_ff;
    assign result_chan_o = result_chan_ff;

    // Threshold per channel, ambient last
    assign thr_w[0] = proximity_channel1_threshold_i;
    assign thr_w[1] = proximity_channel2_threshold_i;
    assign thr_w[2] = proximity_channel3_threshold_i;
    assign thr_w[AMB_CHAN] = ambient_threshold_i;

    stho_chan_if chan_if [NCHAN] ();

    // One filter per channel, fed from the registered result
    for (genvar g = 0; g < NCHAN; g++)
    begin : g_chan
        assign chan_if[g].smp_vld = result_vld_ff && (result_chan_ff == 2'(g));
        assign chan_if[g].value = result_ff;
        assign chan_if[g].threshold = thr_w[g];
        // band on proximity thresholds; ambient band is not handled here
        assign chan_if[g].hyst = (g == AMB_CHAN) ? 16'h0000 : prox_hyst_val;
        assign chan_if[g].mask = (g == AMB_CHAN) ? ambient_history_mask_ff
                                                 : proximity_history_mask_ff;
        assign chan_above[g] = chan_if[g].above;
        assign chan_changed[g] = chan_if[g].changed;

        stho_hist_filter u_filt (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .ch(chan_if[g].filt)
        );

        if (g != AMB_CHAN)
        begin : g_prox_chk
            // status rises only past threshold plus band
            prox_band_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
                $rose(chan_if[g].above) |->
                    ({1'b0, $past(result_ff)} >
                     {1'b0, $past(thr_w[g])} + {1'b0, $past(prox_hyst_val)}))
                else $error("proximity status rose inside the band");
        end
    end

    assign proximity_near_o = chan_above[2:0];
    assign ambient_above_o = chan_above[AMB_CHAN];

    // Events: status changes and overrange results
    assign evt_set = {result_vld_ff & ovr_ff, chan_changed};
    assign evt_clr = (wr && sel_irq_stat) ? wb_dat_i[NEVT-1:0] : '0;
    // A new event outranks a clear in the same cycle
    assign nxt_irq_stat = (irq_stat_ff & ~evt_clr) | evt_set;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_ff <= '0;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // Level interrupt, follows the masked status directly
    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    // Answer lasts exactly one cycle
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Offset code right after reset
    ofs_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !$past(rst_n_i) |-> (measurement_offset_ff == 8'h80) && (ofs_val == 16'd256))
        else $error("offset not at its reset value");

    // Hysteresis example code
    hyst_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        proximity_hysteresis_ff == 8'h48 |-> prox_hyst_val == 16'd24)
        else $error("hysteresis code 0x48 not expanded to 24");

    // Offset example codes
    ofs_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (measurement_offset_ff == 8'h60 |-> ofs_val == 16'd64) and
        (measurement_offset_ff == 8'h70 |-> ofs_val == 16'd128))
        else $error("offset code expansion wrong");

    // Reported value carries the offset
    offset_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        meas_vld_i && !meas_ovr_i && (meas_i + ofs_val != 16'hffff)
        |=> result_ff == 16'($past(meas_i) + $past(ofs_val)))
        else $error("result does not include the offset");

    // Valid results without overrange never show the overrange code
    no_false_ovr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        result_vld_ff && !ovr_ff |-> result_ff != 16'hffff)
        else $error("valid result reported as overrange");

    // Overrange input reports the reserved code and raises its event
    ovr_report_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        meas_vld_i && meas_ovr_i |=> result_ff == 16'hffff ##1 irq_stat_ff[EVT_OVR])
        else $error("overrange not reported");

    // A set in the clearing cycle survives
    set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        evt_set[EVT_OVR] |=> irq_stat_ff[EVT_OVR])
        else $error("event lost against a clear");

    // Every taken request is answered on the next edge
    ack_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req |=> wb_ack_o)
        else $error("request not answered on the next edge");

    // A write lands at the edge it is taken, before the master sees ack
    ofs_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr && sel_meas_ofs |=> measurement_offset_ff == $past(wb_dat_i[7:0]))
        else $error("offset write did not land");

    // The proximity run mask takes the written value
    hist_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr && sel_prox_hist |=> proximity_history_mask_ff == $past(wb_dat_i[7:0]))
        else $error("history mask write did not land");

    // Write-one clears every bit that has no new event
    stat_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr && sel_irq_stat |=> (irq_stat_ff & $past(wb_dat_i[NEVT-1:0] & ~evt_set)) == '0)
        else $error("status bit not cleared by a written one");

endmodule

// [testbench/stho_host_model.sv]
// Host model: classic Wishbone master that configures the block's registers.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps
module stho_host_model
    import stho_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Wishbone master side
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [9:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    // Idle bus at time zero
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 10'h000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h00000000;
    end

    // One classic cycle; no limit of its own, the bench watchdog ends a hang
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= {idx, 2'b00};
        wb_sel_o <= 4'hf;
        wb_dat_o <= {24'h000000, d};
        do
            @(posedge clk_i);
        while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        // Released data inverts so a stale word never looks valid
        wb_dat_o <= ~{24'h000000, d};
    endtask

    // reserved recovery byte only ever gets zero
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, idx, (idx == IDX_EMIT_REC) ? 8'h00 : d, q);
    endtask

    // Register read
    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        xfer(1'b0, idx, 8'h00, q);
    endtask
endmodule

// [testbench/stho_bench.sv]
// Self-checking bench for the threshold, history and offset block.
// Assumes the host model drives the register bus and this module the samples.
`timescale 1ns/1ps
module stho_bench
    import stho_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [9:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dw, wb_dr, q;
    logic meas_vld = 1'b0;
    logic [1:0] meas_chan = 2'h0;
    logic [15:0] meas = 16'h0000;
    logic meas_ovr = 1'b0;
    logic [15:0] thr = 16'h1000;
    logic [15:0] result, b;
    logic result_vld, amb, irq;
    logic [1:0] result_chan;
    logic [2:0] near;
    logic [17:0] exp_q[$];
    logic [15:0] off = 16'h0100;
    logic [31:0] rnd = 32'h4c34;
    int fails = 0;
    int compares = 0;
    localparam logic [7:0] RI [8] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h20, 8'h21};
    localparam logic [7:0] RV [8] = '{8'h48, 8'h03, 8'h03, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] HM [3] = '{8'h03, 8'h07, 8'hff};
    localparam int HN [3] = '{2, 3, 8};
    localparam logic [7:0] OC [3] = '{8'h60, 8'h70, 8'h80};
    localparam logic [15:0] OV [3] = '{16'h0040, 16'h0080, 16'h0100};

    // Clock, 20 ns period
    always #10 clk_i = ~clk_i;

    stho_host_model stho_host_model_i (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
        .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dw),
        .wb_dat_i(wb_dr), .wb_ack_i(wb_ack));

    stho_top stho_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dw),
        .wb_dat_o(wb_dr), .wb_ack_o(wb_ack), .meas_vld_i(meas_vld), .meas_chan_i(meas_chan),
        .meas_i(meas), .meas_ovr_i(meas_ovr), .proximity_channel1_threshold_i(thr),
        .proximity_channel2_threshold_i(thr), .proximity_channel3_threshold_i(thr),
        .ambient_threshold_i(thr), .result_o(result), .result_vld_o(result_vld),
        .result_chan_o(result_chan), .proximity_near_o(near), .ambient_above_o(amb),
        .irq_o(irq));

    // Counted comparison, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        stho_host_model_i.wr(a, d);
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic stat(input int ch);
        return (ch == AMB_CHAN) ? amb : near[ch];
    endfunction

    // One sample; expected report noted first, then a settle gap for the filter
    task automatic send(input logic [1:0] ch, input logic [15:0] m, input logic ovr);
        logic [15:0] s;
        s = m + off;
        if (ovr)
            s = 16'hffff;
        else if (s == 16'hffff)
            s = 16'hfffe;
        exp_q.push_back({ch, s});
        @(posedge clk_i);
        meas_vld <= 1'b1;
        meas_chan <= ch;
        meas <= m;
        meas_ovr <= ovr;
        @(posedge clk_i);
        meas_vld <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // A run of equal reported values, then the channel status
    task automatic seq(input int ch, input int n, input logic [15:0] r, input logic e);
        repeat (n) send(2'(ch), r - off, 1'b0);
        chk({31'h0, stat(ch)}, {31'h0, e});
    endtask

    // Result watcher takes the oldest note for each reported value
    always @(posedge clk_i)
    begin
        if (result_vld === 1'b1)
        begin
            if (exp_q.size() > 0)
                chk({14'h0, result_chan, result}, {14'h0, exp_q.pop_front()});
            else
                chk(32'h1, 32'h0);
        end
    end

    // Watchdog, far beyond the several hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        end_sim();
    end

    task automatic end_sim();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            stho_host_model_i.rd(RI[i], q);
            chk(q, {24'h0, RV[i]});
        end
        wr(8'h1b, 8'h5a);
        stho_host_model_i.rd(8'h1b, q);
        chk(q, 32'h0);
        wr(IDX_EMIT_REC, 8'h00);
        $display("reset test done");
        for (int c = 0; c < 3; c++)
        begin
            seq(c, 2, thr + 16'd24, 1'b0);
            seq(c, 2, thr + 16'd25, 1'b1);
            seq(c, 2, thr - 16'd24, 1'b1);
            seq(c, 2, thr - 16'd25, 1'b0);
        end
        $display("hysteresis test done");
        for (int i = 0; i < 3; i++)
        begin
            wr(IDX_PROX_HIST, HM[i]);
            wr(IDX_AMB_HIST, HM[i]);
            for (int c = 0; c < 4; c += 3)
            begin
                b = (c == 3) ? 16'd1 : 16'd25;
                seq(c, HN[i] - 1, thr + b, 1'b0);
                seq(c, 1, thr + b, 1'b1);
                seq(c, HN[i] - 1, thr - b, 1'b1);
                seq(c, 1, thr - b, 1'b0);
            end
        end
        $display("history test done");
        // Sticky events, mask and write-one clear
        stho_host_model_i.rd(IDX_IRQ_STAT, q);
        chk(q, 32'h0f);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_STAT, 8'h0f);
        wr(IDX_IRQ_MASK, 8'h08);
        wr(IDX_PROX_HIST, 8'h03);
        wr(IDX_AMB_HIST, 8'h03);
        stho_host_model_i.rd(IDX_IRQ_MASK, q);
        chk(q, 32'h08);
        seq(3, 2, thr + 16'd1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_STAT, 8'h08);
        chk({31'h0, irq}, 32'h0);
        seq(0, 2, thr + 16'd25, 1'b1);
        chk({31'h0, irq}, 32'h0);
        stho_host_model_i.rd(IDX_IRQ_STAT, q);
        chk(q, 32'h01);
        stho_host_model_i.rd(IDX_CHAN_STAT, q);
        chk(q, 32'h09);
        $display("interrupt test done");
        for (int i = 0; i < 3; i++)
        begin
            wr(IDX_MEAS_OFS, OC[i]);
            off = OV[i];
            repeat (4)
            begin
                rnd = lfsr(rnd);
                send(rnd[1:0], rnd[31:16], 1'b0);
            end
        end
        send(2'd0, 16'hffff, 1'b0);
        send(2'd1, 16'hfeff, 1'b0);
        stho_host_model_i.rd(IDX_RESULT_LO, q);
        chk(q, 32'hfe);
        stho_host_model_i.rd(IDX_RESULT_HI, q);
        chk(q, 32'hff);
        // Overrange event and a write-one clear meet on one edge; the set must win
        fork
            send(2'd2, 16'h1234, 1'b1);
            begin
                @(posedge clk_i);
                wr(IDX_IRQ_STAT, 8'h10);
            end
        join
        stho_host_model_i.rd(IDX_IRQ_STAT, q);
        chk({31'h0, q[EVT_OVR]}, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(exp_q.size(), 32'h0);
        $display("offset test done");
        end_sim();
    end
endmodule
